// ### logic/bvs_ctrl.sv
// start-up sequencer, target decode and register slave of the buck controller
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module bvs_ctrl
    import bvs_pkg::*;
#(
    parameter int unsigned POR_CYC  = POR_DELAY_CYC,
    parameter int unsigned STEP_CYC = FAST_STEP_CYC
)
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    input  wire logic        supply_ok,
    input  wire logic        regulator_enable_input,
    input  wire logic        pwm_req,
    input  wire logic        phase_zero,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             output_good_flag,
    output logic             attention_n,
    output logic [7:0]       setpoint_code,
    output logic             synth_clamp,
    output logic             high_side_gate,
    output logic             low_side_gate,
    output logic             irq
);
    bvs_state_t      state;
    logic [7:0]      target_voltage_code;
    logic            reverse_block_mode;
    logic            short_ontime_option;
    logic            fast_slew;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0]     por_cnt;
    logic [15:0]     step_cnt;
    logic            resp;
    logic            wr_target;
    logic            reject;
    logic            ramp_done;
    logic [15:0]     step_len;

    function automatic logic [11:0] code_to_mv(input logic [7:0] code);
        if (code == CODE_ZERO)
            return 12'h000;
        return 12'(MV_BASE + (int'(code) - 1) * MV_STEP);
    endfunction

    function automatic logic over_max(input logic [7:0] code);
        return int'(code_to_mv(code)) > MV_MAX;
    endfunction

    // one wait state: every access answers on the second edge
    assign avs_waitrequest = (avs_read || avs_write) && !resp;
    wire   accept = (avs_read || avs_write) && resp;

    assign wr_target = accept && avs_write && avs_address == REG_TARGET && avs_byteenable[0];
    assign reject    = wr_target && over_max(avs_writedata[7:0]);
    assign step_len  = fast_slew ? 16'(STEP_CYC) : 16'(STEP_CYC * SLOW_DIV);
    assign ramp_done = setpoint_code == target_voltage_code;
    assign synth_clamp = reverse_block_mode && state == BVS_RUN;
    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            resp <= 1'b0;
        else if (clk_en)
            resp <= (avs_read || avs_write) && !resp;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            target_voltage_code <= CODE_ZERO;
            reverse_block_mode  <= 1'b0;
            short_ontime_option <= 1'b0;
            fast_slew           <= 1'b0;
            irq_mask            <= '0;
        end
        else if (clk_en && accept && avs_write)
        begin
            if (wr_target && !reject)
                target_voltage_code <= avs_writedata[7:0];
            if (avs_address == REG_CTRL && avs_byteenable[0])
            begin
                reverse_block_mode  <= avs_writedata[BIT_DE];
                short_ontime_option <= avs_writedata[BIT_SHORT];
                fast_slew           <= avs_writedata[BIT_FAST];
            end
            if (avs_address == REG_CTRL && avs_byteenable[1])
                irq_mask <= avs_writedata[BIT_IRQ_MASK_LSB +: IRQ_W];
        end
    end

    // start-up sequencer
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state    <= BVS_OFF;
            por_cnt  <= '0;
            step_cnt <= '0;
            setpoint_code    <= CODE_ZERO;
            output_good_flag <= 1'b0;
            attention_n      <= 1'b1;
        end
        else if (clk_en)
        begin
            case (state)
                BVS_OFF:
                begin
                    if (supply_ok)
                    begin
                        state   <= BVS_WAIT;
                        por_cnt <= '0;
                    end
                end
                BVS_WAIT:
                begin
                    // settle delay after threshold before the ramp may begin
                    if (por_cnt < 32'(POR_CYC) - 32'h1)
                        por_cnt <= por_cnt + 32'h1;
                    else if (regulator_enable_input)
                    begin
                        state    <= BVS_RAMP;
                        step_cnt <= '0;
                    end
                end
                BVS_RAMP:
                begin
                    if (ramp_done)
                    begin
                        state            <= BVS_RUN;
                        output_good_flag <= 1'b1;
                        attention_n      <= 1'b0;
                    end
                    else if (step_cnt + 16'h1 >= step_len)
                    begin
                        step_cnt <= '0;
                        // one code per step towards the latest target
                        if (setpoint_code < target_voltage_code)
                            setpoint_code <= setpoint_code + 8'h01;
                        else
                            setpoint_code <= setpoint_code - 8'h01;
                    end
                    else
                        step_cnt <= step_cnt + 16'h1;
                end
                BVS_RUN:
                begin
                    attention_n <= 1'b1;
                    if (setpoint_code != target_voltage_code)
                    begin
                        if (step_cnt + 16'h1 >= step_len)
                        begin
                            step_cnt <= '0;
                            setpoint_code <= (setpoint_code < target_voltage_code) ?
                                setpoint_code + 8'h01 : setpoint_code - 8'h01;
                        end
                        else
                            step_cnt <= step_cnt + 16'h1;
                    end
                    else
                        step_cnt <= '0;
                end
                default: state <= BVS_OFF;
            endcase
            // losing supply, or losing enable outside off and wait, drops everything back to off
            if (!supply_ok || (state != BVS_OFF && state != BVS_WAIT
                               && !regulator_enable_input))
            begin
                state            <= BVS_OFF;
                setpoint_code    <= CODE_ZERO;
                output_good_flag <= 1'b0;
                attention_n      <= 1'b1;
            end
        end
    end

    // sticky events; a set in the clear cycle wins
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            irq_status <= '0;
        else if (clk_en)
        begin
            logic [IRQ_W-1:0] set_v;
            logic [IRQ_W-1:0] clr_v;
            set_v = '0;
            clr_v = '0;
            set_v[IRQ_DONE]   = state == BVS_RAMP && ramp_done;
            set_v[IRQ_REJECT] = reject;
            if (accept && avs_write && avs_address == REG_IRQ && avs_byteenable[0])
                clr_v = avs_writedata[IRQ_W-1:0];
            irq_status <= (irq_status & ~clr_v) | set_v;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            avs_readdata <= '0;
        else if (clk_en && avs_read && !resp)
        begin
            case (avs_address)
                REG_CTRL:   avs_readdata <= {16'h0000, 6'h00, irq_mask, 5'h00,
                                             fast_slew, short_ontime_option,
                                             reverse_block_mode};
                REG_TARGET: avs_readdata <= {24'h000000, target_voltage_code};
                REG_STATUS: avs_readdata <= {16'h0000, setpoint_code, 4'h0,
                                             attention_n, output_good_flag, state};
                REG_IRQ:    avs_readdata <= {30'h00000000, irq_status};
                default:    avs_readdata <= 32'h00000000;
            endcase
        end
    end

    bvs_ontime u_ontime
    (
        .ref_clk        (ref_clk),
        .nrst           (nrst),
        .clk_en         (clk_en),
        .run            (state == BVS_RUN),
        .pwm_req        (pwm_req),
        .short_sel      (short_ontime_option),
        .de_mode        (reverse_block_mode),
        .phase_zero     (phase_zero),
        .high_side_gate (high_side_gate),
        .low_side_gate  (low_side_gate)
    );
endmodule

// ### logic/bvs_ontime.sv
// on-time and low-side gate sequencer for one switching pulse
`timescale 1ns/1ps
module bvs_ontime
    import bvs_pkg::*;
#(
    parameter int unsigned LONG_CYC  = LONG_ON_CYC,
    parameter int unsigned SHORT_CYC = SHORT_ON_CYC
)
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic clk_en,
    input  wire logic run,
    input  wire logic pwm_req,
    input  wire logic short_sel,
    input  wire logic de_mode,
    input  wire logic phase_zero,
    output logic      high_side_gate,
    output logic      low_side_gate
);
    bvs_gate_t   st;
    logic [15:0] cnt;

    // pulse rate follows pwm_req from the modulator, so frequency tracks load
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st  <= BVS_IDLE;
            cnt <= '0;
            high_side_gate <= 1'b0;
            low_side_gate  <= 1'b0;
        end
        else if (clk_en)
        begin
            case (st)
                BVS_IDLE:
                begin
                    if (run && pwm_req)
                    begin
                        st  <= BVS_HIGH;
                        cnt <= '0;
                        high_side_gate <= 1'b1;
                        low_side_gate  <= 1'b0;
                    end
                end
                BVS_HIGH:
                begin
                    cnt <= cnt + 16'h1;
                    high_side_gate <= 1'b0;
                    low_side_gate  <= 1'b1;
                    st <= BVS_LOW;
                end
                BVS_LOW:
                begin
                    cnt <= cnt + 16'h1;
                    // fixed high-on to low-off interval per option, unless diode emulation cuts the low gate at phase zero first
                    if (cnt + 16'h1 >= (short_sel ? 16'(SHORT_CYC) : 16'(LONG_CYC)))
                    begin
                        low_side_gate <= 1'b0;
                        st <= BVS_IDLE;
                    end
                    else if (de_mode && phase_zero)
                        low_side_gate <= 1'b0;
                end
                default: st <= BVS_IDLE;
            endcase
            if (!run)
            begin
                st <= BVS_IDLE;
                high_side_gate <= 1'b0;
                low_side_gate  <= 1'b0;
            end
        end
    end
endmodule

// ### logic/bvs_pkg.sv
// constants, register map and types for the buck start-up and gate timing block
package bvs_pkg;
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned POR_DELAY_US   = 1100;
    localparam int unsigned POR_DELAY_CYC  = POR_DELAY_US * CLK_MHZ;
    localparam int unsigned LONG_ON_NS     = 1430;
    localparam int unsigned SHORT_ON_NS    = 1000;
    localparam int unsigned LONG_ON_CYC    = (LONG_ON_NS * CLK_MHZ) / 1000;
    localparam int unsigned SHORT_ON_CYC   = (SHORT_ON_NS * CLK_MHZ) / 1000;
    localparam int unsigned SLOW_DIV       = 4;
    localparam int unsigned FAST_STEP_CYC  = 167;
    localparam int unsigned MV_BASE        = 500;
    localparam int unsigned MV_STEP        = 10;
    localparam int unsigned MV_MAX         = 2300;

    localparam logic [7:0] CODE_ZERO = 8'h00;

    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_TARGET = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_IRQ    = 4'hC;

    localparam int unsigned BIT_DE    = 0;
    localparam int unsigned BIT_SHORT = 1;
    localparam int unsigned BIT_FAST  = 2;
    localparam int unsigned BIT_IRQ_MASK_LSB = 8;

    localparam int unsigned IRQ_DONE   = 0;
    localparam int unsigned IRQ_REJECT = 1;
    localparam int unsigned IRQ_W      = 2;

    typedef enum logic [1:0] { BVS_OFF, BVS_WAIT, BVS_RAMP, BVS_RUN } bvs_state_t;
    typedef enum logic [1:0] { BVS_IDLE, BVS_HIGH, BVS_LOW } bvs_gate_t;
endpackage

// ### tb/buck_vid_startup_and_gate_timing_tb.sv
// self-checking bench: register access, start-up, slew, reject and gate timing
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module buck_vid_startup_and_gate_timing_tb;
    import bvs_pkg::*;
    logic        ref_clk, nrst, clk_en, supply_ok, regulator_enable_input, pwm_req;
    logic        phase_zero, avs_read, avs_write, avs_waitrequest, output_good_flag;
    logic        attention_n, synth_clamp, high_side_gate, low_side_gate, irq;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic [7:0]  setpoint_code, zero_dly;
    int          num_errors, n_compared, attn_lows, n;
    bvs_ctrl #(.POR_CYC(50), .STEP_CYC(2)) DUT (.ref_clk, .nrst, .clk_en, .supply_ok,
        .regulator_enable_input, .pwm_req, .phase_zero, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .output_good_flag, .attention_n, .setpoint_code, .synth_clamp, .high_side_gate,
        .low_side_gate, .irq);
    bvs_phase_model u_phase (.ref_clk, .nrst, .low_side_gate, .zero_dly, .phase_zero);
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        attn_lows += int'(nrst && attention_n === 1'b0);
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge ref_clk);
            n++;
        end
        num_errors += int'(n == 50);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask
    // counts the cycles between two successive setpoint steps
    task automatic gap(input int e);
        logic [7:0] s;
        repeat (2)
        begin
            s = setpoint_code;
            n = 0;
            while (setpoint_code === s && n < 300)
            begin
                @(posedge ref_clk);
                n++;
            end
        end
        `CHK(n, e)
    endtask
    task automatic upto(input logic [7:0] v);
        n = 0;
        while (setpoint_code !== v && n < 3000)
        begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(setpoint_code, v)
    endtask
    task automatic pulse(input int e);
        @(posedge ref_clk);
        pwm_req <= 1'b1;
        @(posedge ref_clk);
        pwm_req <= 1'b0;
        n = 0;
        repeat (400)
        begin
            @(posedge ref_clk);
            n += int'(high_side_gate === 1'b1 || low_side_gate === 1'b1);
        end
        `CHK(n, e)
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        {nrst, supply_ok, regulator_enable_input, pwm_req, avs_read, avs_write} = 6'h00;
        clk_en = 1'b1;
        avs_byteenable = 4'hF;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        zero_dly = 8'h00;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        bus(1'b1, REG_TARGET, 32'h000000B5);
        rd(REG_TARGET, 32'h000000B5);
        bus(1'b1, REG_TARGET, 32'h000000B6);
        rd(REG_TARGET, 32'h000000B5);
        rd(REG_IRQ, 32'h00000002);
        rd(4'h2, 32'h00000000);
        bus(1'b1, REG_CTRL, 32'h00000300);
        // the mask lands at the accepting edge; irq follows it combinationally and is sampled one edge later
        @(posedge ref_clk);
        `CHK(irq, 1'b1)
        bus(1'b1, REG_IRQ, 32'h00000002);
        @(posedge ref_clk);
        `CHK(irq, 1'b0)
        bus(1'b1, REG_TARGET, 32'h00000010);
        supply_ok <= 1'b1;
        repeat (100) @(posedge ref_clk);
        `CHK(setpoint_code, 8'h00)
        regulator_enable_input <= 1'b1;
        gap(SLOW_DIV * 2);
        upto(8'h10);
        repeat (3) @(posedge ref_clk);
        `CHK(output_good_flag, 1'b1)
        `CHK(attn_lows, 1)
        `CHK(irq, 1'b1)
        bus(1'b1, REG_CTRL, 32'h00000004);
        bus(1'b1, REG_TARGET, 32'h00000020);
        gap(2);
        upto(8'h20);
        pulse(LONG_ON_CYC);
        bus(1'b1, REG_CTRL, 32'h00000002);
        pulse(SHORT_ON_CYC);
        `CHK(synth_clamp, 1'b0)
        // diode emulation with the phase node reaching zero early in the pulse
        bus(1'b1, REG_CTRL, 32'h00000003);
        zero_dly <= 8'h14;
        // one high cycle, zero_dly low cycles, one more low cycle to react
        pulse(22);
        `CHK(synth_clamp, 1'b1)
        // clock enable low freezes the gate sequencer: no pulse may start
        clk_en <= 1'b0;
        pulse(0);
        clk_en <= 1'b1;
        nrst <= 1'b0;
        supply_ok <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        bus(1'b1, REG_TARGET, 32'h00000008);
        supply_ok <= 1'b1;
        n = 0;
        while (setpoint_code === 8'h00 && n < 300)
        begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(n >= 50 && n <= 70, 1'b1)
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        complete_run();
    end
endmodule

// ### tb/bvs_chk_assertions.sv
// concurrent checks on start-up, ramp and gate outputs
`timescale 1ns/1ps
module bvs_chk
    import bvs_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire logic       supply_ok,
    input wire logic       phase_zero,
    input wire logic       output_good_flag,
    input wire logic       attention_n,
    input wire logic [7:0] setpoint_code,
    input wire logic       synth_clamp,
    input wire logic       high_side_gate,
    input wire logic       low_side_gate
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    // counter instead of a long repetition keeps the tools fast
    logic [9:0] low_cnt;
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            low_cnt <= 10'h000;
        else
            low_cnt <= low_side_gate ? low_cnt + 10'h001 : 10'h000;
    end
    sequence s_handover;
        !high_side_gate && (low_side_gate || phase_zero);
    endsequence
    a_no_start: assert property (!supply_ok |=> !output_good_flag)
        else $error("good flag without supply");
    a_ramp_step: assert property ($changed(setpoint_code) && setpoint_code != 8'h00
        |-> (setpoint_code - $past(setpoint_code)) inside {8'h01, 8'hFF})
        else $error("setpoint moved by more than one code");
    a_good_attn: assert property ($fell(attention_n) |-> output_good_flag)
        else $error("attention without good flag");
    a_attn_pulse: assert property (!attention_n |=> attention_n)
        else $error("attention held past one cycle");
    a_step_gap: assert property ($changed(setpoint_code) && setpoint_code != 8'h00
        |=> $stable(setpoint_code))
        else $error("setpoint steps too close");
    a_de_cut: assert property (synth_clamp && phase_zero && low_side_gate
        |-> ##[1:2] !low_side_gate)
        else $error("low gate kept on at zero phase");
    a_gate_excl: assert property (!(high_side_gate && low_side_gate))
        else $error("both gates on");
    a_high_pulse: assert property ($rose(high_side_gate) |=> s_handover)
        else $error("high gate not handed to low gate");
    a_on_bound: assert property (low_cnt < LONG_ON_CYC)
        else $error("low gate on too long");
endmodule
bind bvs_ctrl bvs_chk u_chk (.ref_clk, .nrst, .supply_ok, .phase_zero, .output_good_flag,
    .attention_n, .setpoint_code, .synth_clamp, .high_side_gate, .low_side_gate);

// ### tb/bvs_phase_model.sv
// phase node model: reads zero a set number of cycles into low-side conduction
`timescale 1ns/1ps
module bvs_phase_model
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       low_side_gate,
    input  wire logic [7:0] zero_dly,
    output logic            phase_zero
);
    logic [7:0] cnt;
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            cnt <= 8'h00;
        else
            cnt <= low_side_gate ? cnt + 8'h01 : 8'h00;
    end
    // zero delay stands for heavy load: current never reaches zero in the pulse
    assign phase_zero = low_side_gate && zero_dly != 8'h00 && cnt >= zero_dly;
endmodule
